// *** rtl/ckgen_top.sv ***
// Clock generator control: oscillator enables, main clock select, CPU divider and hold-off
`timescale 1ns/1ps
module ckgen_top (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic stop_exec_i,
  input wire logic stop_wake_i,
  input wire logic hs_osc_settled_i,
  input wire logic res_stab_done_i,
  input wire logic ls_sw_stop_ok_i,
  input wire logic int_hs_tick_i,
  input wire logic hs_sys_tick_i,
  input wire logic ls_tick_i,
  input wire logic [1:0] h1_tap_sel_i,
  output logic resonator_run_o,
  output logic ext_clk_gate_o,
  output logic int_hs_osc_run_o,
  output logic ls_osc_run_o,
  output logic pll_run_o,
  output logic pll_ratio_x12_o,
  output logic pin_a_gpio_o,
  output logic pin_b_gpio_o,
  output logic main_on_hs_sys_o,
  output logic cpu_tick_o,
  output logic wdt_tick_o,
  output logic h1_tick_o
);

  // Register state
  logic ext_mode_q;
  logic res_mode_q;
  logic gain_q;
  logic gain_locked_q;
  logic stable_q;
  logic ls_halt_q;
  logic hs_halt_q;
  logic main_halt_q;
  logic xsel_q;
  logic xsel_locked_q;
  logic msel0_q;
  logic mcs_q;
  logic [7:0] cpu_div_q;
  logic pll_ratio_q;
  logic pll_halt_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Sequencer state
  ckgen_pkg::ckgen_state_e state_q;
  ckgen_pkg::ckgen_state_e state_d;
  logic [ckgen_pkg::HOLD_CNT_W-1:0] hold_cnt_q;
  logic [ckgen_pkg::HOLD_CNT_W-1:0] hold_cnt_d;

  // Address decode
  logic sel_pin_mode;
  logic sel_int_osc;
  logic sel_main_sel;
  logic sel_main_osc;
  logic sel_cpu_div;
  logic sel_pll;
  logic wr_pin_mode;
  logic wr_int_osc;
  logic wr_main_sel;
  logic wr_main_osc;
  logic wr_cpu_div;
  logic wr_pll;

  assign sel_pin_mode = (reg_addr_i == ckgen_pkg::ADDR_PIN_MODE);
  assign sel_int_osc = (reg_addr_i == ckgen_pkg::ADDR_INT_OSC);
  assign sel_main_sel = (reg_addr_i == ckgen_pkg::ADDR_MAIN_SEL);
  assign sel_main_osc = (reg_addr_i == ckgen_pkg::ADDR_MAIN_OSC);
  assign sel_cpu_div = (reg_addr_i == ckgen_pkg::ADDR_CPU_DIV);
  assign sel_pll = (reg_addr_i == ckgen_pkg::ADDR_PLL_CTRL);
  assign wr_pin_mode = reg_wr_i & sel_pin_mode;
  assign wr_int_osc = reg_wr_i & sel_int_osc;
  assign wr_main_sel = reg_wr_i & sel_main_sel;
  assign wr_main_osc = reg_wr_i & sel_main_osc;
  assign wr_cpu_div = reg_wr_i & sel_cpu_div;
  assign wr_pll = reg_wr_i & sel_pll;

  // Derived modes
  logic in_stop;
  logic pin_res_mode;
  logic pin_ext_mode;
  logic hs_sys_sel;
  logic gain_set_evt;
  logic cpu_on_resonator;
  logic hs_sys_avail;
  logic main_tick;
  logic cpu_gate;

  assign in_stop = (state_q == ckgen_pkg::CKGEN_STOPPED);
  assign pin_res_mode = ~ext_mode_q & res_mode_q;
  assign pin_ext_mode = ext_mode_q & res_mode_q;
  // Only the 11 code selects the high-speed system clock; 10 is a forbidden combination
  assign hs_sys_sel = xsel_q & msel0_q;
  // Gain takes effect on the first write only; later writes cannot lower it
  assign gain_set_evt = wr_pin_mode & ~gain_locked_q & reg_wdata_i[ckgen_pkg::BIT_GAIN_HIGH];
  assign cpu_on_resonator = mcs_q & pin_res_mode;
  assign hs_sys_avail = (pin_res_mode | pin_ext_mode) & ~main_halt_q & ~in_stop;

  // Oscillator enables
  assign resonator_run_o = pin_res_mode & ~main_halt_q & ~in_stop;
  assign ext_clk_gate_o = pin_ext_mode & ~main_halt_q & ~in_stop;
  assign int_hs_osc_run_o = ~hs_halt_q & ~in_stop;
  assign ls_osc_run_o = ~(ls_halt_q & ls_sw_stop_ok_i);
  assign pll_run_o = ~pll_halt_q & hs_sys_avail;
  assign pll_ratio_x12_o = pll_ratio_q;
  assign pin_a_gpio_o = ~pin_res_mode;
  assign pin_b_gpio_o = ~(pin_res_mode | pin_ext_mode);
  assign main_on_hs_sys_o = mcs_q;

  // Main clock source: the low-speed tick never reaches this mux
  logic int_hs_live;
  logic hs_sys_live;

  // Each source is masked by its own enable, so a halted oscillator cannot leak ticks through the mux
  assign int_hs_live = int_hs_tick_i & int_hs_osc_run_o;
  assign hs_sys_live = hs_sys_tick_i & hs_sys_avail;
  assign main_tick = mcs_q ? hs_sys_live : int_hs_live;

  // CPU divider
  ckgen_div_if cpu_div_bus ();
  logic [2:0] cpu_div_sel;

  // Reserved selector codes fall back to the slowest ratio
  assign cpu_div_sel = (cpu_div_q[2:0] > ckgen_pkg::CPU_DIV_MAX_SEL) ? ckgen_pkg::CPU_DIV_MAX_SEL : cpu_div_q[2:0];
  assign cpu_div_bus.tick_in = main_tick;
  assign cpu_div_bus.shift = {1'b0, cpu_div_sel};

  ckgen_tick_div #(
    .W(4)
  ) u_cpu_div (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .div(cpu_div_bus)
  );

  // The CPU sees no ticks while stopped or held after a gain change
  assign cpu_gate = (state_q == ckgen_pkg::CKGEN_RUN);
  assign cpu_tick_o = cpu_div_bus.tick_out & cpu_gate;

  // Low-speed prescaler for timer H1
  ckgen_div_if ls_div_bus ();
  logic [3:0] ls_shift;
  logic ls_live;

  assign ls_live = ls_tick_i & ls_osc_run_o;
  assign ls_shift = (h1_tap_sel_i == ckgen_pkg::LS_TAP_DIV128) ? ckgen_pkg::LS_SHIFT_128 :
                    (h1_tap_sel_i == ckgen_pkg::LS_TAP_DIV512) ? ckgen_pkg::LS_SHIFT_512 : 4'h0;
  assign ls_div_bus.tick_in = ls_live & (h1_tap_sel_i != ckgen_pkg::LS_TAP_OFF);
  assign ls_div_bus.shift = ls_shift;

  ckgen_tick_div #(
    .W(9)
  ) u_ls_div (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .div(ls_div_bus)
  );

  assign wdt_tick_o = ls_live;
  assign h1_tick_o = ls_div_bus.tick_out;

  // Sequencer: stop mode and CPU clock hold-off
  logic hold_done;

  assign hold_done = (hold_cnt_q == ckgen_pkg::HOLD_CNT_W'(ckgen_pkg::GAIN_HOLD_CYC - 1));

  // The hold count restarts from zero on every entry, so each hold lasts the full time
  always_comb begin
    state_d = state_q;
    hold_cnt_d = '0;
    case (state_q)
      ckgen_pkg::CKGEN_RUN: begin
        // A stop request wins over a gain write in the same cycle
        if (stop_exec_i) begin
          state_d = ckgen_pkg::CKGEN_STOPPED;
        end else if (gain_set_evt) begin
          state_d = ckgen_pkg::CKGEN_HOLD;
        end
      end
      ckgen_pkg::CKGEN_STOPPED: begin
        if (stop_wake_i) begin
          if (!gain_q) begin
            state_d = ckgen_pkg::CKGEN_RUN;
          end else if (cpu_on_resonator) begin
            state_d = ckgen_pkg::CKGEN_WAIT_STAB;
          end else begin
            state_d = ckgen_pkg::CKGEN_HOLD;
          end
        end
      end
      ckgen_pkg::CKGEN_HOLD: begin
        hold_cnt_d = hold_cnt_q + ckgen_pkg::HOLD_CNT_W'(1);
        if (hold_done) begin
          state_d = ckgen_pkg::CKGEN_RUN;
        end
      end
      ckgen_pkg::CKGEN_WAIT_STAB: begin
        if (res_stab_done_i) begin
          state_d = ckgen_pkg::CKGEN_RUN;
        end
      end
      default: begin
        state_d = ckgen_pkg::CKGEN_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_q <= ckgen_pkg::CKGEN_RUN;
      hold_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end

  // Clock pin mode select register
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ext_mode_q <= ckgen_pkg::RST_PIN_MODE[ckgen_pkg::BIT_EXT_CLK_MODE];
      res_mode_q <= ckgen_pkg::RST_PIN_MODE[ckgen_pkg::BIT_RES_MODE];
      gain_q <= ckgen_pkg::RST_PIN_MODE[ckgen_pkg::BIT_GAIN_HIGH];
      gain_locked_q <= 1'b0;
    end else if (wr_pin_mode) begin
      // Pin mode changes are dropped unless the main oscillator is halted (main_halt_q set)
      if (main_halt_q) begin
        ext_mode_q <= reg_wdata_i[ckgen_pkg::BIT_EXT_CLK_MODE];
        res_mode_q <= reg_wdata_i[ckgen_pkg::BIT_RES_MODE];
      end
      if (!gain_locked_q) begin
        gain_q <= reg_wdata_i[ckgen_pkg::BIT_GAIN_HIGH];
        gain_locked_q <= 1'b1;
      end
    end
  end

  // Internal oscillation mode register; stability flag is hardware-owned
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      stable_q <= 1'b0;
      ls_halt_q <= 1'b0;
      hs_halt_q <= 1'b0;
    end else begin
      // Not sticky: halting the oscillator drops the flag until it settles again
      stable_q <= hs_osc_settled_i & int_hs_osc_run_o;
      if (wr_int_osc) begin
        ls_halt_q <= reg_wdata_i[ckgen_pkg::BIT_LS_HALT];
        hs_halt_q <= reg_wdata_i[ckgen_pkg::BIT_HS_HALT];
      end
    end
  end

  // Main oscillator control register
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      main_halt_q <= ckgen_pkg::RST_MAIN_OSC[ckgen_pkg::BIT_MAIN_HALT];
    end else if (wr_main_osc) begin
      main_halt_q <= reg_wdata_i[ckgen_pkg::BIT_MAIN_HALT];
    end
  end

  // Main clock select register; status follows the selection one cycle later
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      xsel_q <= ckgen_pkg::RST_MAIN_SEL[ckgen_pkg::BIT_XSEL];
      xsel_locked_q <= 1'b0;
      msel0_q <= ckgen_pkg::RST_MAIN_SEL[ckgen_pkg::BIT_MSEL0];
      mcs_q <= ckgen_pkg::RST_MAIN_SEL[ckgen_pkg::BIT_MCS];
    end else begin
      mcs_q <= hs_sys_sel;
      if (wr_main_sel) begin
        msel0_q <= reg_wdata_i[ckgen_pkg::BIT_MSEL0];
        if (!xsel_locked_q) begin
          xsel_q <= reg_wdata_i[ckgen_pkg::BIT_XSEL];
          xsel_locked_q <= 1'b1;
        end
      end
    end
  end

  // CPU clock divider and PLL control registers
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cpu_div_q <= ckgen_pkg::RST_CPU_DIV;
      pll_ratio_q <= ckgen_pkg::RST_PLL_CTRL[ckgen_pkg::BIT_PLL_RATIO];
      pll_halt_q <= ckgen_pkg::RST_PLL_CTRL[ckgen_pkg::BIT_PLL_HALT];
    end else begin
      if (wr_cpu_div) begin
        cpu_div_q <= reg_wdata_i & ckgen_pkg::CPU_DIV_WMASK;
      end
      if (wr_pll) begin
        pll_ratio_q <= reg_wdata_i[ckgen_pkg::BIT_PLL_RATIO];
        pll_halt_q <= reg_wdata_i[ckgen_pkg::BIT_PLL_HALT];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (sel_pin_mode) begin
      rdata_d[ckgen_pkg::BIT_EXT_CLK_MODE] = ext_mode_q;
      rdata_d[ckgen_pkg::BIT_RES_MODE] = res_mode_q;
      rdata_d[ckgen_pkg::BIT_GAIN_HIGH] = gain_q;
    end else if (sel_int_osc) begin
      rdata_d[ckgen_pkg::BIT_STABLE] = stable_q;
      rdata_d[ckgen_pkg::BIT_LS_HALT] = ls_halt_q;
      rdata_d[ckgen_pkg::BIT_HS_HALT] = hs_halt_q;
    end else if (sel_main_sel) begin
      rdata_d[ckgen_pkg::BIT_XSEL] = xsel_q;
      rdata_d[ckgen_pkg::BIT_MCS] = mcs_q;
      rdata_d[ckgen_pkg::BIT_MSEL0] = msel0_q;
    end else if (sel_main_osc) begin
      rdata_d[ckgen_pkg::BIT_MAIN_HALT] = main_halt_q;
    end else if (sel_cpu_div) begin
      rdata_d = cpu_div_q;
    end else if (sel_pll) begin
      rdata_d[ckgen_pkg::BIT_PLL_RATIO] = pll_ratio_q;
      rdata_d[ckgen_pkg::BIT_PLL_HALT] = pll_halt_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule

// *** rtl/ckgen_pkg.sv ***
// Constants, register map and state types of the clock generator control block
package ckgen_pkg;

  localparam logic [15:0] ADDR_PIN_MODE = 16'hff9f;
  localparam logic [15:0] ADDR_INT_OSC = 16'hffa0;
  localparam logic [15:0] ADDR_MAIN_SEL = 16'hffa1;
  localparam logic [15:0] ADDR_MAIN_OSC = 16'hffa2;
  localparam logic [15:0] ADDR_CPU_DIV = 16'hff9e;
  localparam logic [15:0] ADDR_PLL_CTRL = 16'hff9d;

  localparam logic [7:0] RST_PIN_MODE = 8'h00;
  localparam logic [7:0] RST_MAIN_OSC = 8'h80;
  localparam logic [7:0] RST_MAIN_SEL = 8'h00;
  localparam logic [7:0] RST_CPU_DIV = 8'h01;
  localparam logic [7:0] RST_PLL_CTRL = 8'h01;

  localparam int BIT_EXT_CLK_MODE = 7;
  localparam int BIT_RES_MODE = 6;
  localparam int BIT_GAIN_HIGH = 0;
  localparam int BIT_STABLE = 7;
  localparam int BIT_LS_HALT = 1;
  localparam int BIT_HS_HALT = 0;
  localparam int BIT_MAIN_HALT = 7;
  localparam int BIT_XSEL = 2;
  localparam int BIT_MCS = 1;
  localparam int BIT_MSEL0 = 0;
  localparam int BIT_PLL_RATIO = 1;
  localparam int BIT_PLL_HALT = 0;

  // Writable bits of the CPU divider register: bits 3 and 7 held at zero
  localparam logic [7:0] CPU_DIV_WMASK = 8'h77;
  localparam logic [2:0] CPU_DIV_MAX_SEL = 3'h4;

  // Low-speed tap selection for timer H1
  localparam logic [1:0] LS_TAP_OFF = 2'h0;
  localparam logic [1:0] LS_TAP_DIV1 = 2'h1;
  localparam logic [1:0] LS_TAP_DIV128 = 2'h2;
  localparam logic [1:0] LS_TAP_DIV512 = 2'h3;
  localparam logic [3:0] LS_SHIFT_128 = 4'h7;
  localparam logic [3:0] LS_SHIFT_512 = 4'h9;

  localparam int CLK_PERIOD_NS = 10;
  localparam int GAIN_HOLD_US = 5;
  localparam int GAIN_HOLD_CYC = (GAIN_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CNT_W = 10;

  typedef enum logic [1:0] {
    CKGEN_RUN,
    CKGEN_STOPPED,
    CKGEN_HOLD,
    CKGEN_WAIT_STAB
  } ckgen_state_e;

endpackage

// *** rtl/ckgen_div_if.sv ***
// Interface between the clock generator top and its tick dividers
`timescale 1ns/1ps
interface ckgen_div_if;
  logic tick_in;
  logic [3:0] shift;
  logic tick_out;

  modport owner (output tick_in, output shift, input tick_out);
  modport divider (input tick_in, input shift, output tick_out);
endinterface

// *** rtl/ckgen_tick_div.sv ***
// Tick divider: one output pulse per 2**shift input ticks
`timescale 1ns/1ps
module ckgen_tick_div #(
  parameter int W = 9
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  ckgen_div_if.divider div
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W-1:0] limit;
  logic at_limit;
  logic tick_q;

  assign limit = W'((1 << div.shift) - 1);
  assign at_limit = (cnt_q >= limit);
  assign cnt_d = at_limit ? '0 : cnt_q + W'(1);
  assign div.tick_out = tick_q;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div.tick_in & at_limit;
      if (div.tick_in) begin
        cnt_q <= cnt_d;
      end
    end
  end

endmodule

// *** tb/ckgen_xtal_model.sv ***
// Behavioural resonator or external clock source on the high-speed pins
`timescale 1ns/1ps
module ckgen_xtal_model #(
  parameter int TICK_DIV = 8,
  parameter int STAB_CYC = 200
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic resonator_run_i,
  input wire logic ext_clk_gate_i,
  output logic hs_sys_tick_o,
  output logic res_stab_done_o
);
  int ph = 0;
  int age = 0;
  wire live = resonator_run_i || ext_clk_gate_i;
  // A stopped crystal loses its amplitude, so stabilization restarts from zero
  always @(negedge ref_clk_i) begin
    ph <= (!reset_n_i || !live) ? 0 : (ph + 1) % TICK_DIV;
    age <= (!reset_n_i || !live) ? 0 : age + 1;
    hs_sys_tick_o <= reset_n_i && live && ph == 0;
    res_stab_done_o <= reset_n_i && resonator_run_i && age >= STAB_CYC;
  end
endmodule

// *** tb/ckgen_chk.sv ***
// Concurrent checks on the clock generator control ports
`timescale 1ns/1ps
module ckgen_chk (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic stop_exec_i,
  input wire logic ls_sw_stop_ok_i,
  input wire logic resonator_run_o,
  input wire logic ext_clk_gate_o,
  input wire logic int_hs_osc_run_o,
  input wire logic ls_osc_run_o,
  input wire logic pll_run_o,
  input wire logic pll_ratio_x12_o,
  input wire logic pin_a_gpio_o,
  input wire logic pin_b_gpio_o,
  input wire logic main_on_hs_sys_o,
  input wire logic cpu_tick_o,
  input wire logic wdt_tick_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic gain_seen_q;
  logic [9:0] hold_q;
  wire pin_wr = reg_wr_i && reg_addr_i == ckgen_pkg::ADDR_PIN_MODE;
  wire pll_wr = reg_wr_i && reg_addr_i == ckgen_pkg::ADDR_PLL_CTRL;
  wire gain_set = pin_wr && !gain_seen_q && reg_wdata_i[0] && !stop_exec_i;
  // Only the first pin-mode write after reset can start the gain hold-off
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      gain_seen_q <= 1'b0;
      hold_q <= 10'h0;
    end else begin
      gain_seen_q <= gain_seen_q || pin_wr;
      hold_q <= gain_set ? 10'h1f4 : (hold_q != 10'h0 ? hold_q - 10'h1 : 10'h0);
    end
  end
  chk_gain_hold_quiet: assert property (hold_q != 10'h0 |-> !cpu_tick_o)
    else $error("cpu tick during gain hold-off");
  chk_stop_osc_off: assert property (stop_exec_i |=> !int_hs_osc_run_o && !resonator_run_o && !ext_clk_gate_o)
    else $error("oscillator left running after stop");
  chk_pll_ratio_reg: assert property (pll_wr |=> pll_ratio_x12_o == $past(reg_wdata_i[1]))
    else $error("pll ratio does not follow write");
  chk_pll_needs_src: assert property (pll_run_o |-> resonator_run_o || ext_clk_gate_o)
    else $error("pll runs without source");
  chk_res_pin_use: assert property (resonator_run_o |-> !pin_a_gpio_o && !pin_b_gpio_o)
    else $error("resonator runs on general pins");
  chk_reset_start: assert property ($rose(reset_n_i) |-> int_hs_osc_run_o && ls_osc_run_o && !resonator_run_o && !main_on_hs_sys_o)
    else $error("wrong oscillator state after reset");
  chk_ls_strap_lock: assert property (!ls_sw_stop_ok_i |-> ls_osc_run_o)
    else $error("low-speed oscillator halted without strap");
  chk_status_by_write: assert property ($rose(main_on_hs_sys_o) |->
    $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == ckgen_pkg::ADDR_MAIN_SEL)
    else $error("main status changed without write");
  chk_wdt_dead_ls: assert property (!ls_osc_run_o && !$past(ls_osc_run_o) |-> !wdt_tick_o)
    else $error("watchdog tick with low-speed oscillator off");
endmodule
bind ckgen_top ckgen_chk u_ckgen_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .stop_exec_i(stop_exec_i), .ls_sw_stop_ok_i(ls_sw_stop_ok_i),
  .resonator_run_o(resonator_run_o), .ext_clk_gate_o(ext_clk_gate_o), .int_hs_osc_run_o(int_hs_osc_run_o),
  .ls_osc_run_o(ls_osc_run_o), .pll_run_o(pll_run_o), .pll_ratio_x12_o(pll_ratio_x12_o),
  .pin_a_gpio_o(pin_a_gpio_o), .pin_b_gpio_o(pin_b_gpio_o), .main_on_hs_sys_o(main_on_hs_sys_o),
  .cpu_tick_o(cpu_tick_o), .wdt_tick_o(wdt_tick_o));

// *** tb/ckgen_top_tb.sv ***
// Self-checking bench for the clock generator control block
`timescale 1ns/1ps
module ckgen_top_tb;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [15:0] reg_addr_i = 16'h0;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h0;
  logic reg_rd_i = 1'b0;
  logic stop_exec_i = 1'b0;
  logic stop_wake_i = 1'b0;
  logic hs_osc_settled_i = 1'b0;
  logic ls_sw_stop_ok_i = 1'b0;
  logic int_hs_tick_i = 1'b0;
  logic ls_tick_i = 1'b0;
  logic [1:0] h1_tap_sel_i = 2'h0;
  logic [7:0] reg_rdata_o;
  wire hs_sys_tick_i, res_stab_done_i, resonator_run_o, ext_clk_gate_o, int_hs_osc_run_o, ls_osc_run_o;
  wire pll_run_o, pll_ratio_x12_o, pin_a_gpio_o, pin_b_gpio_o, main_on_hs_sys_o, cpu_tick_o, wdt_tick_o, h1_tick_o;
  int err_total = 0;
  int n_compared = 0;
  int phase = 0;
  ckgen_top u_ckgen_top (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .stop_exec_i(stop_exec_i), .stop_wake_i(stop_wake_i), .hs_osc_settled_i(hs_osc_settled_i),
    .res_stab_done_i(res_stab_done_i), .ls_sw_stop_ok_i(ls_sw_stop_ok_i), .int_hs_tick_i(int_hs_tick_i),
    .hs_sys_tick_i(hs_sys_tick_i), .ls_tick_i(ls_tick_i), .h1_tap_sel_i(h1_tap_sel_i),
    .resonator_run_o(resonator_run_o), .ext_clk_gate_o(ext_clk_gate_o), .int_hs_osc_run_o(int_hs_osc_run_o),
    .ls_osc_run_o(ls_osc_run_o), .pll_run_o(pll_run_o), .pll_ratio_x12_o(pll_ratio_x12_o),
    .pin_a_gpio_o(pin_a_gpio_o), .pin_b_gpio_o(pin_b_gpio_o), .main_on_hs_sys_o(main_on_hs_sys_o),
    .cpu_tick_o(cpu_tick_o), .wdt_tick_o(wdt_tick_o), .h1_tick_o(h1_tick_o));
  ckgen_xtal_model u_ckgen_xtal_model (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .resonator_run_i(resonator_run_o), .ext_clk_gate_i(ext_clk_gate_o),
    .hs_sys_tick_o(hs_sys_tick_i), .res_stab_done_o(res_stab_done_i));
  always #5 ref_clk_i = ~ref_clk_i;
  // Internal oscillators sped up: 6 cycles high-speed, 8 cycles low-speed
  always @(negedge ref_clk_i) begin
    phase <= phase + 1;
    int_hs_tick_i <= (phase % 6) == 0;
    ls_tick_i <= (phase % 8) == 0;
  end
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge ref_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge ref_clk_i);
    reg_rd_i = 1'b0;
    @(negedge ref_clk_i);
    check("register read", 16'(reg_rdata_o), 16'(exp));
  endtask
  task automatic count(input int sel, input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(negedge ref_clk_i);
      n += ((sel == 0 ? cpu_tick_o : sel == 1 ? h1_tick_o : wdt_tick_o) === 1'b1);
    end
  endtask
  function automatic logic [1:0] gpio_exp(input logic [1:0] m);
    return {m != 2'h1, m == 2'h0 || m == 2'h2};
  endfunction
  initial begin
    #600000;
    err_total++;
    conclude();
  end
  initial begin
    int n;
    logic [7:0] v;
    logic [15:0] ra [6] = '{ckgen_pkg::ADDR_PIN_MODE, ckgen_pkg::ADDR_INT_OSC, ckgen_pkg::ADDR_MAIN_SEL,
      ckgen_pkg::ADDR_MAIN_OSC, ckgen_pkg::ADDR_CPU_DIV, 16'hff00};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h01, 8'h00};
    int sh [3] = '{0, 7, 9};
    v = 8'($urandom(8));
    repeat (10) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    hs_osc_settled_i = 1'b1;
    wr(ckgen_pkg::ADDR_INT_OSC, 8'h02);
    rd(ckgen_pkg::ADDR_INT_OSC, 8'h82);
    check("ls run", 16'(ls_osc_run_o), 16'h1);
    ls_sw_stop_ok_i = 1'b1;
    wr(ckgen_pkg::ADDR_INT_OSC, 8'h02);
    count(2, 64, n);
    check("ls stopped", 16'({ls_osc_run_o, n == 0}), 16'h1);
    wr(ckgen_pkg::ADDR_INT_OSC, 8'h00);
    foreach (sh[i]) begin
      h1_tap_sel_i = 2'(i + 1);
      count(1, 32 << sh[i], n);
      check("h1 ticks", 16'(n >= 3 && n <= 5), 16'h1);
    end
    for (int c = 0; c < 5; c++) begin
      v = 8'($urandom);
      v[2:0] = 3'(c);
      wr(ckgen_pkg::ADDR_CPU_DIV, v);
      rd(ckgen_pkg::ADDR_CPU_DIV, v & 8'h77);
      count(0, 96 << c, n);
      check("cpu ticks", 16'(n >= 15 && n <= 17), 16'h1);
    end
    wr(ckgen_pkg::ADDR_CPU_DIV, 8'h00);
    wr(ckgen_pkg::ADDR_PIN_MODE, 8'h41);
    count(0, 490, n);
    check("hold ticks", 16'(n), 16'h0);
    count(0, 100, n);
    check("resumed", 16'(n > 8), 16'h1);
    for (int m = 0; m < 4; m++) begin
      wr(ckgen_pkg::ADDR_PIN_MODE, {2'(m), 6'h00});
      check("pin use", 16'({pin_a_gpio_o, pin_b_gpio_o}), 16'(gpio_exp(2'(m))));
    end
    wr(ckgen_pkg::ADDR_PIN_MODE, 8'h40);
    rd(ckgen_pkg::ADDR_PIN_MODE, 8'h41);
    wr(ckgen_pkg::ADDR_MAIN_OSC, 8'h00);
    check("resonator on", 16'(resonator_run_o), 16'h1);
    wr(ckgen_pkg::ADDR_PIN_MODE, 8'hc0);
    rd(ckgen_pkg::ADDR_PIN_MODE, 8'h41);
    wr(ckgen_pkg::ADDR_PLL_CTRL, 8'h02);
    check("pll x12 run", 16'({pll_run_o, pll_ratio_x12_o}), 16'h3);
    wr(ckgen_pkg::ADDR_PLL_CTRL, 8'h01);
    check("pll x8 halt", 16'({pll_run_o, pll_ratio_x12_o}), 16'h0);
    repeat (250) @(negedge ref_clk_i);
    wr(ckgen_pkg::ADDR_MAIN_SEL, 8'h05);
    rd(ckgen_pkg::ADDR_MAIN_SEL, 8'h07);
    count(0, 128, n);
    check("hs sys ticks", 16'(n >= 15 && n <= 17), 16'h1);
    wr(ckgen_pkg::ADDR_INT_OSC, 8'h01);
    check("int hs off", 16'(int_hs_osc_run_o), 16'h0);
    @(negedge ref_clk_i);
    stop_exec_i = 1'b1;
    @(negedge ref_clk_i);
    stop_exec_i = 1'b0;
    count(0, 50, n);
    check("stopped", 16'({resonator_run_o, n == 0}), 16'h1);
    stop_wake_i = 1'b1;
    @(negedge ref_clk_i);
    stop_wake_i = 1'b0;
    count(0, 150, n);
    check("stab wait", 16'(n), 16'h0);
    count(0, 400, n);
    check("woke", 16'(n > 8), 16'h1);
    // Back to the internal clock, then move the pins to external clock input
    wr(ckgen_pkg::ADDR_INT_OSC, 8'h00);
    wr(ckgen_pkg::ADDR_MAIN_SEL, 8'h04);
    wr(ckgen_pkg::ADDR_MAIN_OSC, 8'h80);
    wr(ckgen_pkg::ADDR_PIN_MODE, 8'hc0);
    wr(ckgen_pkg::ADDR_MAIN_OSC, 8'h00);
    check("ext gate", 16'({ext_clk_gate_o, resonator_run_o, pin_a_gpio_o, pin_b_gpio_o}), 16'ha);
    rd(ckgen_pkg::ADDR_MAIN_SEL, 8'h04);
    @(negedge ref_clk_i);
    stop_exec_i = 1'b1;
    @(negedge ref_clk_i);
    stop_exec_i = 1'b0;
    check("ext stopped", 16'({ext_clk_gate_o, int_hs_osc_run_o}), 16'h0);
    stop_wake_i = 1'b1;
    @(negedge ref_clk_i);
    stop_wake_i = 1'b0;
    count(0, 490, n);
    check("wake hold", 16'(n), 16'h0);
    count(0, 100, n);
    check("wake resumed", 16'(n > 8), 16'h1);
    conclude();
  end
endmodule
